// ### logic/ccsp_device.sv
// Purpose: device end of the three-wire config port
// Assumes: link clock made by the host, still outside frames
// Notes:   register space lives in the link domain
`timescale 1ns/10ps
module ccsp_device #(
	parameter int MEM_WORDS = ccsp_pkg::MEM_WORDS_DEF,
	parameter int FRAME_GAP = ccsp_pkg::FRAME_GAP_CYC
)(
	input  wire logic                        clock_in,
	input  wire logic                        rst_n_in,
	ccsp_link_if.dev                         link,
	output logic [ccsp_pkg::ADDR_W-1:0]      reg_wr_addr_out,
	output logic [ccsp_pkg::DATA_W-1:0]      reg_wr_data_out,
	output logic                             reg_wr_pulse_out,
	output logic                             soft_reset_out,
	output logic                             secondary_en_out
);
	import ccsp_pkg::*;

	localparam int IDX_W = $clog2(MEM_WORDS);
	localparam int GAP_W = $clog2(FRAME_GAP + 1);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic                   cs_s1_r;
	logic                   cs_s2_r;
	logic [GAP_W-1:0]       gap_cnt_r;
	logic                   gap_r;
	logic                   frame_rst_n;
	ccsp_phase_t            phase_r;
	logic [2:0]             bit_r;
	logic [7:0]             sr_r;
	logic [7:0]             hi_r;
	logic                   rw_r;
	logic [ADDR_W-1:0]      addr_r;
	logic [7:0]             tx_r;
	logic                   turn_r;
	logic                   lsb_r;
	logic                   asc_r;
	logic [7:0]             mem [MEM_WORDS];
	logic                   wr_tgl_r;
	logic                   srst_tgl_r;
	logic [ADDR_W-1:0]      wr_addr_x_r;
	logic [7:0]             wr_data_x_r;
	logic                   wr_s1_r;
	logic                   wr_s2_r;
	logic                   wr_s3_r;
	logic                   sr_s1_r;
	logic                   sr_s2_r;
	logic                   sr_s3_r;
	logic                   active;
	logic                   byte_done;
	logic [7:0]             rx_byte;
	logic                   wr_now;
	logic [ADDR_W-1:0]      rd_addr;
	logic [7:0]             rd_val;

	// ----------------------------------------
	// select watch in system domain
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cs_s1_r <= 1'h1;
			cs_s2_r <= 1'h1;
		end else begin
			cs_s1_r <= link.chip_select_n;
			cs_s2_r <= cs_s1_r;
		end
	end

	// long idle ends the frame and frees the pins
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gap_cnt_r <= '0;
			gap_r     <= 1'h1;
		end else if (!cs_s2_r) begin
			gap_cnt_r <= '0;
			gap_r     <= 1'h0;
		end else if (gap_cnt_r == GAP_W'(FRAME_GAP - 1)) begin
			gap_r     <= 1'h1;
		end else begin
			gap_cnt_r <= gap_cnt_r + GAP_W'(1);
		end
	end

	assign secondary_en_out = gap_r;
	assign frame_rst_n      = rst_n_in & ~gap_r;

	// ----------------------------------------
	// link domain shifter
	// ----------------------------------------
	assign active    = ~link.chip_select_n;
	assign byte_done = (bit_r == 3'h7);
	assign rx_byte   = shift_in(sr_r, link.sdio, lsb_r);
	assign wr_now    = active & byte_done & (phase_r == PH_DATA) & ~rw_r;

	// frame position survives select stalls
	always_ff @(posedge link.sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			phase_r <= PH_HI;
			bit_r   <= 3'h0;
			sr_r    <= 8'h00;
			hi_r    <= 8'h00;
			rw_r    <= 1'h0;
			addr_r  <= '0;
			tx_r    <= 8'h00;
		end else if (active) begin
			sr_r  <= rx_byte;
			bit_r <= bit_r + 3'h1;
			if (phase_r == PH_HI && bit_r == 3'h0) begin
				rw_r <= link.sdio;
			end
			if (byte_done) begin
				case (phase_r)
					PH_HI: begin
						hi_r    <= rx_byte;
						phase_r <= PH_LO;
					end
					PH_LO: begin
						addr_r  <= rd_addr;
						tx_r    <= rd_val;
						phase_r <= PH_DATA;
					end
					PH_DATA: begin
						addr_r <= rd_addr;
						tx_r   <= rd_val;
					end
					default: begin
						phase_r <= PH_HI;
					end
				endcase
			end
		end
	end

	// readback source
	always_comb begin
		rd_addr = (phase_r == PH_LO) ? addr_join(hi_r, rx_byte, lsb_r) : addr_step(addr_r, asc_r);
		if (rd_addr == CFG_ADDR) begin
			rd_val = cfg_byte(lsb_r, asc_r);
		end else if (rd_addr < MEM_WORDS) begin
			rd_val = mem[rd_addr[IDX_W-1:0]];
		end else begin
			rd_val = 8'h00;
		end
	end

	// ----------------------------------------
	// register space and config bits
	// ----------------------------------------
	always_ff @(posedge link.sclk or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lsb_r <= CFG_LSB_RST;
			asc_r <= CFG_ASC_RST;
			for (int i = 0; i < MEM_WORDS; i++) begin
				mem[i] <= 8'h00;
			end
		end else if (wr_now) begin
			if (addr_r == CFG_ADDR) begin
				lsb_r <= cfg_lsb(rx_byte);
				asc_r <= cfg_asc(rx_byte);
				if (cfg_srst(rx_byte)) begin
					for (int i = 0; i < MEM_WORDS; i++) begin
						mem[i] <= 8'h00;
					end
				end
			end else if (addr_r < MEM_WORDS) begin
				mem[addr_r[IDX_W-1:0]] <= rx_byte;
			end
		end
	end

	// write events for the system side
	always_ff @(posedge link.sclk or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_tgl_r    <= 1'h0;
			srst_tgl_r  <= 1'h0;
			wr_addr_x_r <= '0;
			wr_data_x_r <= 8'h00;
		end else if (wr_now) begin
			wr_tgl_r    <= ~wr_tgl_r;
			wr_addr_x_r <= addr_r;
			wr_data_x_r <= rx_byte;
			if (addr_r == CFG_ADDR && cfg_srst(rx_byte)) begin
				srst_tgl_r <= ~srst_tgl_r;
			end
		end
	end

	// ----------------------------------------
	// data pin turnaround
	// ----------------------------------------
	always_ff @(negedge link.sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			turn_r <= 1'h0;
		end else if (active && phase_r == PH_DATA && rw_r) begin
			turn_r <= 1'h1;
		end
	end

	assign link.sdio_dev_oe  = turn_r & active;
	assign link.sdio_dev_out = bit_pick(tx_r, bit_r, lsb_r);

	// ----------------------------------------
	// crossing into system domain
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_s1_r <= 1'h0;
			wr_s2_r <= 1'h0;
			wr_s3_r <= 1'h0;
			sr_s1_r <= 1'h0;
			sr_s2_r <= 1'h0;
			sr_s3_r <= 1'h0;
		end else begin
			wr_s1_r <= wr_tgl_r;
			wr_s2_r <= wr_s1_r;
			wr_s3_r <= wr_s2_r;
			sr_s1_r <= srst_tgl_r;
			sr_s2_r <= sr_s1_r;
			sr_s3_r <= sr_s2_r;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_wr_pulse_out <= 1'h0;
			soft_reset_out   <= 1'h0;
			reg_wr_addr_out  <= '0;
			reg_wr_data_out  <= 8'h00;
		end else begin
			reg_wr_pulse_out <= wr_s2_r ^ wr_s3_r;
			soft_reset_out   <= sr_s2_r ^ sr_s3_r;
			if (wr_s2_r ^ wr_s3_r) begin
				reg_wr_addr_out <= wr_addr_x_r;
				reg_wr_data_out <= wr_data_x_r;
			end
		end
	end
endmodule

// ### logic/ccsp_pkg.sv
// Purpose: shared constants, types and helpers of the serial config port
// Assumes: 25 MHz system clock, link clock made by the host end
// Notes:   used by both ends and the self-checking bench
package ccsp_pkg;
	// ----------------------------------------
	// widths and timing
	// ----------------------------------------
	localparam int ADDR_W        = 15;
	localparam int DATA_W        = 8;
	localparam int CLK_PERIOD_NS = 40;
	localparam int SRST_WAIT_MS  = 5;
	localparam int SRST_WAIT_CYC = SRST_WAIT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CNT_W         = $clog2(SRST_WAIT_CYC + 1);
	localparam int FRAME_GAP_CYC = 64;
	localparam int HOST_GAP_CYC  = 2 * FRAME_GAP_CYC;
	localparam int SETUP_CYC     = 8;
	localparam int SCLK_HALF_CYC = 4;
	localparam int MEM_WORDS_DEF = 16;
	// ----------------------------------------
	// first configuration register
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] CFG_ADDR = 15'h0000;
	localparam int CFG_SRST_HI = 7;
	localparam int CFG_LSB_HI  = 6;
	localparam int CFG_ASC_HI  = 5;
	localparam int CFG_ASC_LO  = 2;
	localparam int CFG_LSB_LO  = 1;
	localparam int CFG_SRST_LO = 0;
	localparam logic CFG_LSB_RST = 1'h0;
	localparam logic CFG_ASC_RST = 1'h0;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		PH_HI   = 2'h0,
		PH_LO   = 2'h1,
		PH_DATA = 2'h3
	} ccsp_phase_t;
	typedef enum logic [2:0] {
		HS_IDLE   = 3'h0,
		HS_SETUP  = 3'h1,
		HS_SHIFT  = 3'h3,
		HS_FINISH = 3'h2,
		HS_GAP    = 3'h6,
		HS_STALL  = 3'h7
	} ccsp_hstate_t;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic bit_pick(input logic [7:0] b, input logic [2:0] i, input logic lsb);
		return lsb ? b[i] : b[3'h7 - i];
	endfunction
	function automatic logic [7:0] shift_in(input logic [7:0] s, input logic d, input logic lsb);
		return lsb ? {d, s[7:1]} : {s[6:0], d};
	endfunction
	function automatic logic [ADDR_W-1:0] addr_join(input logic [7:0] hi, input logic [7:0] lo, input logic lsb);
		return {(lsb ? hi[7:1] : hi[6:0]), lo};
	endfunction
	function automatic logic [7:0] instr_hi(input logic rw, input logic [ADDR_W-1:0] a, input logic lsb);
		return lsb ? {a[14:8], rw} : {rw, a[14:8]};
	endfunction
	function automatic logic [ADDR_W-1:0] addr_step(input logic [ADDR_W-1:0] a, input logic asc);
		return asc ? a + 15'h0001 : a - 15'h0001;
	endfunction
	function automatic logic cfg_srst(input logic [7:0] d);
		return d[CFG_SRST_HI] | d[CFG_SRST_LO];
	endfunction
	function automatic logic cfg_lsb(input logic [7:0] d);
		return cfg_srst(d) ? CFG_LSB_RST : (d[CFG_LSB_HI] | d[CFG_LSB_LO]);
	endfunction
	function automatic logic cfg_asc(input logic [7:0] d);
		return cfg_srst(d) ? CFG_ASC_RST : (d[CFG_ASC_HI] | d[CFG_ASC_LO]);
	endfunction
	function automatic logic [7:0] cfg_byte(input logic lsb, input logic asc);
		return {1'h0, lsb, asc, 2'h0, asc, lsb, 1'h0};
	endfunction
endpackage

// ### logic/ccsp_link_if.sv
// Purpose: three-wire link between host end and device end
// Assumes: data wire idles high when nobody drives
// Notes:   device enable wins if both drive
`timescale 1ns/10ps
interface ccsp_link_if;
	logic sclk;
	logic chip_select_n;
	logic sdio_host_out;
	logic sdio_host_oe;
	logic sdio_dev_out;
	logic sdio_dev_oe;
	logic sdio;

	assign sdio = sdio_dev_oe ? sdio_dev_out : (sdio_host_oe ? sdio_host_out : 1'h1);

	modport dev (
		input  sclk,
		input  chip_select_n,
		input  sdio,
		output sdio_dev_out,
		output sdio_dev_oe
	);
	modport host (
		output sclk,
		output chip_select_n,
		output sdio_host_out,
		output sdio_host_oe,
		input  sdio
	);
endinterface

// ### logic/ccsp_host.sv
// Purpose: host end driving the three-wire config port
// Assumes: one command at a time, link clock divided from clock_in
// Notes:   tracks bit order and address direction it has written
`timescale 1ns/10ps
module ccsp_host #(
	parameter int SCLK_HALF = ccsp_pkg::SCLK_HALF_CYC,
	parameter int SETUP     = ccsp_pkg::SETUP_CYC,
	parameter int GAP_WAIT  = ccsp_pkg::HOST_GAP_CYC,
	parameter int SRST_WAIT = ccsp_pkg::SRST_WAIT_CYC
)(
	input  wire logic                        clock_in,
	input  wire logic                        rst_n_in,
	ccsp_link_if.host                        link,
	input  wire logic                        cmd_valid_in,
	input  wire logic                        cmd_read_in,
	input  wire logic [ccsp_pkg::ADDR_W-1:0] cmd_addr_in,
	input  wire logic [7:0]                  cmd_len_in,
	input  wire logic [ccsp_pkg::DATA_W-1:0] wdata_in,
	input  wire logic                        stall_in,
	output logic                             cmd_ready_out,
	output logic                             wdata_take_out,
	output logic [ccsp_pkg::DATA_W-1:0]      rdata_out,
	output logic                             rdata_valid_out,
	output logic                             done_out
);
	import ccsp_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	ccsp_hstate_t       state_r;
	ccsp_phase_t        phase_r;
	logic [CNT_W-1:0]   cnt_r;
	logic               sclk_r;
	logic               cs_n_r;
	logic               oe_r;
	logic               out_r;
	logic [2:0]         bit_r;
	logic [7:0]         txb_r;
	logic [7:0]         rx_r;
	logic               rw_r;
	logic [ADDR_W-1:0]  addr_r;
	logic [7:0]         remain_r;
	logic               lsb_r;
	logic               asc_r;
	logic               srst_pend_r;
	logic               sd_s1_r;
	logic               sd_s2_r;
	logic               cfg_wr;
	logic               nlsb;

	assign link.sclk          = sclk_r;
	assign link.chip_select_n = cs_n_r;
	assign link.sdio_host_oe  = oe_r;
	assign link.sdio_host_out = out_r;

	assign cfg_wr = (phase_r == PH_DATA) & ~rw_r & (addr_r == CFG_ADDR);
	assign nlsb   = cfg_wr ? cfg_lsb(txb_r) : lsb_r;

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sd_s1_r <= 1'h1;
			sd_s2_r <= 1'h1;
		end else begin
			sd_s1_r <= link.sdio;
			sd_s2_r <= sd_s1_r;
		end
	end

	// ----------------------------------------
	// frame sequencer
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= HS_IDLE;
			phase_r <= PH_HI;
			cnt_r <= '0;
			sclk_r <= 1'h0;
			cs_n_r <= 1'h1;
			oe_r <= 1'h0;
			out_r <= 1'h0;
			bit_r <= 3'h0;
			txb_r <= 8'h00;
			rx_r <= 8'h00;
			rw_r <= 1'h0;
			addr_r <= '0;
			remain_r <= 8'h00;
			lsb_r <= CFG_LSB_RST;
			asc_r <= CFG_ASC_RST;
			srst_pend_r <= 1'h0;
			cmd_ready_out <= 1'h1;
			wdata_take_out <= 1'h0;
			rdata_out <= 8'h00;
			rdata_valid_out <= 1'h0;
			done_out <= 1'h0;
		end else begin
			wdata_take_out  <= 1'h0;
			rdata_valid_out <= 1'h0;
			done_out        <= 1'h0;
			case (state_r)
				HS_IDLE: begin
					if (cmd_valid_in) begin
						rw_r <= cmd_read_in;
						addr_r <= cmd_addr_in;
						remain_r <= cmd_len_in;
						txb_r <= instr_hi(cmd_read_in, cmd_addr_in, lsb_r);
						out_r <= bit_pick(instr_hi(cmd_read_in, cmd_addr_in, lsb_r), 3'h0, lsb_r);
						oe_r <= 1'h1;
						cs_n_r <= 1'h0;
						phase_r <= PH_HI;
						bit_r <= 3'h0;
						cnt_r <= '0;
						cmd_ready_out <= 1'h0;
						state_r <= HS_SETUP;
					end
				end
				HS_SETUP: begin
					cnt_r <= cnt_r + CNT_W'(1);
					if (cnt_r == CNT_W'(SETUP - 1)) begin
						cnt_r <= '0;
						state_r <= HS_SHIFT;
					end
				end
				HS_SHIFT: begin
					cnt_r <= cnt_r + CNT_W'(1);
					if (cnt_r == CNT_W'(SCLK_HALF - 1)) begin
						cnt_r <= '0;
						sclk_r <= ~sclk_r;
						if (!sclk_r) begin
							rx_r <= shift_in(rx_r, sd_s2_r, lsb_r);
						end else if (bit_r != 3'h7) begin
							bit_r <= bit_r + 3'h1;
							out_r <= bit_pick(txb_r, bit_r + 3'h1, lsb_r);
						end else begin
							bit_r <= 3'h0;
							case (phase_r)
								PH_HI: begin
									phase_r <= PH_LO;
									txb_r <= addr_r[7:0];
									out_r <= bit_pick(addr_r[7:0], 3'h0, lsb_r);
								end
								PH_LO: begin
									phase_r <= PH_DATA;
									oe_r <= ~rw_r;
									if (!rw_r) begin
										txb_r <= wdata_in;
										wdata_take_out <= 1'h1;
										out_r <= bit_pick(wdata_in, 3'h0, lsb_r);
									end
								end
								default: begin
									if (rw_r) begin
										rdata_out <= rx_r;
										rdata_valid_out <= 1'h1;
									end
									if (cfg_wr) begin
										lsb_r <= cfg_lsb(txb_r);
										asc_r <= cfg_asc(txb_r);
										srst_pend_r <= cfg_srst(txb_r);
									end
									addr_r <= addr_step(addr_r, asc_r);
									remain_r <= remain_r - 8'h01;
									if (remain_r == 8'h01) begin
										oe_r <= 1'h0;
										state_r <= HS_FINISH;
									end else begin
										if (!rw_r) begin
											txb_r <= wdata_in;
											wdata_take_out <= 1'h1;
											out_r <= bit_pick(wdata_in, 3'h0, nlsb);
										end
										if (stall_in) begin
											cs_n_r <= 1'h1;
											oe_r <= 1'h0;
											state_r <= HS_STALL;
										end
									end
								end
							endcase
						end
					end
				end
				HS_STALL: begin
					if (!stall_in) begin
						cs_n_r <= 1'h0;
						oe_r <= ~rw_r;
						cnt_r <= '0;
						state_r <= HS_SETUP;
					end
				end
				HS_FINISH: begin
					cnt_r <= cnt_r + CNT_W'(1);
					if (cnt_r == CNT_W'(SCLK_HALF - 1)) begin
						cnt_r <= '0;
						cs_n_r <= 1'h1;
						state_r <= HS_GAP;
					end
				end
				HS_GAP: begin
					cnt_r <= cnt_r + CNT_W'(1);
					if (cnt_r == (srst_pend_r ? CNT_W'(SRST_WAIT - 1) : CNT_W'(GAP_WAIT - 1))) begin
						cnt_r <= '0;
						srst_pend_r <= 1'h0;
						done_out <= 1'h1;
						cmd_ready_out <= 1'h1;
						state_r <= HS_IDLE;
					end
				end
				default: begin
					state_r <= HS_IDLE;
				end
			endcase
		end
	end
endmodule

// ### bench/ccsp_link_sva.sv
// Purpose: concurrent checks on the three-wire link
// Assumes: all link signals sampled on clock_in
// Notes:   sees interface signals only
`timescale 1ns/10ps
module ccsp_link_sva (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic sdio_host_out,
	input wire logic sdio_host_oe,
	input wire logic sdio_dev_out,
	input wire logic sdio_dev_oe,
	input wire logic sdio
);
	// ----------------------------------------
	// bit counter of link clock rises
	// ----------------------------------------
	logic       sclk_q_r;
	logic [2:0] rise_cnt_r;

	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sclk_q_r <= 1'h0;
		end else begin
			sclk_q_r <= sclk;
		end
	end
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rise_cnt_r <= 3'h0;
		end else if (sclk && !sclk_q_r) begin
			rise_cnt_r <= rise_cnt_r + 3'h1;
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	no_dev_drive_a: assert property (chip_select_n |-> !sdio_dev_oe)
		else $error("device drives data with select high");
	no_contention_a: assert property (!(sdio_dev_oe && sdio_host_oe))
		else $error("both ends drive data");
	sclk_idle_a: assert property (chip_select_n |-> !sclk)
		else $error("link clock runs outside select");
	start_setup_a: assert property ($fell(chip_select_n) |-> !sclk [*2])
		else $error("link clock rises at select fall");
	sclk_high_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("link clock high time wrong");
	host_stable_a: assert property (sclk && sdio_host_oe |-> $stable(sdio_host_out))
		else $error("host data moves while clock high");
	turn_point_a: assert property ($rose(sdio_dev_oe) |->
		rise_cnt_r == 3'h0 && ($fell(sclk) || $fell(chip_select_n)))
		else $error("device turns data off a byte boundary");
	dev_release_a: assert property ($fell(sdio_dev_oe) |-> $rose(chip_select_n))
		else $error("device releases data inside frame");
	byte_count_a: assert property ($rose(chip_select_n) |-> rise_cnt_r == 3'h0)
		else $error("select rises off a byte boundary");
endmodule

// ### bench/converter_config_serial_port_test.sv
// Purpose: self-checking bench joining host and device ends
// Assumes: shortened frame gap and soft reset wait
// Notes:   inputs change on the falling clock edge
`timescale 1ns/10ps
module converter_config_serial_port_test;
	import ccsp_pkg::*;
	logic              clock_in;
	logic              rst_n_in;
	logic              cmd_valid, cmd_read, stall;
	logic [ADDR_W-1:0] cmd_addr, wr_addr;
	logic [7:0]        cmd_len;
	logic [DATA_W-1:0] wdata, rdata, wr_data;
	logic              cmd_ready, wdata_take, rdata_valid, done, wr_pulse, soft_reset, secondary_en;
	logic              sclk_p, sd_p;
	logic [DATA_W-1:0] wq[$], rq[$], wd_q[$];
	logic [ADDR_W-1:0] wa_q[$];
	logic              bit_q[$];
	int                bad_count, n_compared, cyc, cs_rises, srst_seen, sec_low;

	ccsp_link_if i_ccsp_link_if ();
	ccsp_host #(.GAP_WAIT(16), .SRST_WAIT(200)) i_ccsp_host (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .link(i_ccsp_link_if),
		.cmd_valid_in(cmd_valid), .cmd_read_in(cmd_read), .cmd_addr_in(cmd_addr), .cmd_len_in(cmd_len),
		.wdata_in(wdata), .stall_in(stall), .cmd_ready_out(cmd_ready), .wdata_take_out(wdata_take),
		.rdata_out(rdata), .rdata_valid_out(rdata_valid), .done_out(done));
	ccsp_device #(.FRAME_GAP(8)) i_ccsp_device (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .link(i_ccsp_link_if),
		.reg_wr_addr_out(wr_addr), .reg_wr_data_out(wr_data), .reg_wr_pulse_out(wr_pulse),
		.soft_reset_out(soft_reset), .secondary_en_out(secondary_en));
	ccsp_link_sva i_ccsp_link_sva (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .sclk(i_ccsp_link_if.sclk),
		.chip_select_n(i_ccsp_link_if.chip_select_n), .sdio_host_out(i_ccsp_link_if.sdio_host_out),
		.sdio_host_oe(i_ccsp_link_if.sdio_host_oe), .sdio_dev_out(i_ccsp_link_if.sdio_dev_out),
		.sdio_dev_oe(i_ccsp_link_if.sdio_dev_oe), .sdio(i_ccsp_link_if.sdio));
	// ----------------------------------------
	// clock and monitors
	// ----------------------------------------
	initial begin
		clock_in = 1'h0;
		forever #20 clock_in = ~clock_in;
	end
	always @(negedge clock_in) begin
		if (wr_pulse === 1'h1) begin
			wa_q.push_back(wr_addr);
			wd_q.push_back(wr_data);
		end
		if (soft_reset === 1'h1) srst_seen++;
	end
	// wire bit taken half a cycle before each clock rise
	always @(negedge clock_in) begin
		if (i_ccsp_link_if.sclk === 1'h1 && sclk_p === 1'h0 && i_ccsp_link_if.chip_select_n === 1'h0)
			bit_q.push_back(sd_p);
		sclk_p = i_ccsp_link_if.sclk;
		sd_p = i_ccsp_link_if.sdio;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic wrap_up;
		if (bad_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic run(input logic rd, input logic [ADDR_W-1:0] a, input int n, input logic st);
		int   hi;
		logic cs_p;
		hi = 0;
		cs_p = 1'h1;
		cyc = 0;
		cs_rises = 0;
		sec_low = 0;
		rq.delete();
		wa_q.delete();
		wd_q.delete();
		bit_q.delete();
		@(negedge clock_in);
		cmd_valid = 1'h1;
		cmd_read = rd;
		cmd_addr = a;
		cmd_len = n[7:0];
		wdata = wq.size() > 0 ? wq[0] : 8'h00;
		stall = st;
		@(negedge clock_in);
		cmd_valid = 1'h0;
		while (done !== 1'h1 && cyc < 5000) begin
			if (wdata_take === 1'h1) begin
				void'(wq.pop_front());
				wdata = wq.size() > 0 ? wq[0] : 8'h00;
			end
			if (rdata_valid === 1'h1) rq.push_back(rdata);
			if (secondary_en === 1'h0) sec_low = 1;
			if (cs_p === 1'h0 && i_ccsp_link_if.chip_select_n === 1'h1) cs_rises++;
			cs_p = i_ccsp_link_if.chip_select_n;
			if (stall === 1'h1 && cs_p === 1'h1 && cs_rises > 0) hi++;
			if (hi == 3) stall = 1'h0;
			cyc++;
			@(negedge clock_in);
		end
		chk(done, 1'h1);
		chk(secondary_en, 1'h1);
		chk(16'(sec_low), 16'h0001);
	endtask
	task automatic chk_wire(input logic lsb, input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
		logic [23:0] w;
		int          b;
		w = {b0, b1, b2};
		chk(16'(bit_q.size() >= 24), 16'h0001);
		for (int i = 0; i < 24 && i < bit_q.size(); i++) begin
			b = lsb ? i % 8 : 7 - i % 8;
			chk(16'(bit_q[i]), 16'(w[16 - 8 * (i / 8) + b]));
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_stream_msb;
		logic [7:0] d[3];
		d = '{8'hA5, 8'h3C, 8'h0F};
		wq = '{8'hA5, 8'h3C, 8'h0F};
		run(1'h0, 15'h0003, 3, 1'h0);
		for (int i = 0; i < 3; i++) begin
			chk(16'(wa_q[i]), 16'(3 - i));
			chk(16'(wd_q[i]), 16'(d[i]));
		end
		chk(16'(cs_rises), 16'h0001);
		chk_wire(1'h0, 8'h00, 8'h03, 8'hA5);
		run(1'h1, 15'h0003, 3, 1'h1);
		for (int i = 0; i < 3; i++) chk(16'(rq[i]), 16'(d[i]));
		chk(16'(cs_rises), 16'h0002);
		chk_wire(1'h0, 8'h80, 8'h03, 8'hA5);
	endtask
	task automatic t_lsb_asc;
		wq = '{8'h66};
		run(1'h0, CFG_ADDR, 1, 1'h0);
		wq = '{8'h12, 8'h34};
		run(1'h0, 15'h0001, 2, 1'h1);
		chk(16'(wa_q[0]), 16'h0001);
		chk(16'(cs_rises), 16'h0002);
		chk(16'(wd_q[1]), 16'h0034);
		chk(16'(wa_q[1]), 16'h0002);
		chk_wire(1'h1, 8'h00, 8'h01, 8'h12);
		run(1'h1, CFG_ADDR, 1, 1'h0);
		chk(16'(rq[0]), 16'h0066);
		chk_wire(1'h1, 8'h01, 8'h00, 8'h66);
	endtask
	task automatic t_soft_reset;
		srst_seen = 0;
		wq = '{8'h81};
		run(1'h0, CFG_ADDR, 1, 1'h0);
		chk(16'(srst_seen), 16'h0001);
		chk(16'(cyc >= 200), 16'h0001);
		run(1'h1, 15'h0003, 1, 1'h0);
		chk(16'(rq[0]), 16'h0000);
		chk_wire(1'h0, 8'h80, 8'h03, 8'h00);
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst_n_in = 1'h0;
		cmd_valid = 1'h0;
		cmd_read = 1'h0;
		cmd_addr = 15'h0000;
		cmd_len = 8'h00;
		wdata = 8'h00;
		stall = 1'h0;
		bad_count = 0;
		n_compared = 0;
		srst_seen = 0;
		repeat (3) @(negedge clock_in);
		rst_n_in = 1'h1;
		@(negedge clock_in);
		chk(secondary_en, 1'h1);
		chk(cmd_ready, 1'h1);
		t_stream_msb();
		t_lsb_asc();
		t_soft_reset();
		wrap_up();
	end
	// seven commands of under 700 cycles each, well inside 2 ms
	initial begin
		#2000000;
		bad_count++;
		wrap_up();
	end
endmodule
